// ### bench/bus_follower.sv
// Follower side of the shared two-wire bus.
// Assumes the leader sets an enable high to pull its line low.
`timescale 1ns/1ps
`default_nettype none
module bus_follower (
	input  wire logic scl_oe,
	input  wire logic sda_oe,
	input  wire logic hold_scl,
	output logic      scl,
	output logic      sda
);
	// Released lines go to the pull-up level
	assign scl = !(scl_oe || hold_scl);
	assign sda = !sda_oe;
endmodule // bus_follower
`default_nettype wire

// ### bench/bus_timing_props.sv
// Port timing checker for bus_timing.
// Assumes OVERFLOW pulses spaced wider than the hold delay.
`timescale 1ns/1ps
`default_nettype none
module bus_timing_props #(parameter integer TIMEOUT_CYCLES = 50) (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic OVERFLOW,
	input wire logic EXTENDED_HOLD_ENABLE,
	input wire logic SCL_IN,
	input wire logic SCL_OE,
	input wire logic SDA_OE,
	input wire logic READY,
	input wire logic BIT_SAMPLE,
	input wire logic TIMEOUT
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	// Overflows outside READY since the last edge of each enable, and SCL low cycles
	logic [3:0] cs, cd;
	logic       ql, qd;
	int         cl;
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			{cs, cd, ql, qd} <= 10'h3fc;
			cl <= 0;
		end else begin
			ql <= SCL_OE;
			qd <= SDA_OE;
			cs <= (SCL_OE != ql) ? 4'h0 : cs + 4'(OVERFLOW && !READY && cs != 4'hf);
			cd <= (SDA_OE != qd) ? 4'h0 : cd + 4'(OVERFLOW && !READY && cd != 4'hf);
			cl <= SCL_IN ? 0 : cl + 1;
		end
	end
	scl_low_a: assert property ($fell(SCL_OE) && !TIMEOUT |-> cs == 4'h1) else $error("SCL low");
	scl_high_a: assert property ($rose(SCL_OE) |-> cs == 4'h2 || (SDA_OE && cd == 4'h1)) else $error("SCL high");
	bus_free_a: assert property ($rose(SDA_OE) |-> cd >= 4'h2) else $error("Bus free");
	rsta_setup_a: assert property ($rose(SDA_OE) && !SCL_OE |-> cs == 4'h2 || cs >= 4'h4) else $error("START setup");
	stop_setup_a: assert property ($fell(SDA_OE) && !SCL_OE && !TIMEOUT |-> cs == 4'h2) else $error("STOP setup");
	tmo_early_a: assert property ($rose(TIMEOUT) |-> cl >= TIMEOUT_CYCLES) else $error("Early timeout");
	tmo_late_a: assert property (cl == TIMEOUT_CYCLES + 4 |-> TIMEOUT) else $error("Late timeout");
	tmo_clear_a: assert property ($rose(SCL_IN) |-> ##[1:3] !TIMEOUT) else $error("Timeout stuck");
	ext_hold_a: assert property ($fell(READY) && EXTENDED_HOLD_ENABLE && !TIMEOUT |=> $stable(SDA_OE)[*5])
		else $error("Hold");
	cover property ($rose(TIMEOUT));
	cover property ($rose(SDA_OE) && cs == 4'h2);
	cover property (BIT_SAMPLE && EXTENDED_HOLD_ENABLE);
endmodule // bus_timing_props
bind bus_timing bus_timing_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_bus_timing_props (.CLK_SYS(CLK_SYS),
	.RST_N(RST_N), .OVERFLOW(OVERFLOW), .EXTENDED_HOLD_ENABLE(EXTENDED_HOLD_ENABLE), .SCL_IN(SCL_IN),
	.SCL_OE(SCL_OE), .SDA_OE(SDA_OE), .READY(READY), .BIT_SAMPLE(BIT_SAMPLE), .TIMEOUT(TIMEOUT));
`default_nettype wire

// ### bench/bus_timing_tb.sv
// Self-checking bench for bus_timing.
// Assumes the bound checker and the bus_follower model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin failures++; $display("MISMATCH %s %b %b", n, e, s); end end
module bus_timing_tb;
	localparam int TO = 60;
	logic clk = 0, rst_n = 0, ovf = 0, sr = 0, br = 0, bd = 0, pr = 0, ext = 0, dly = 0, hs = 0;
	logic scl_oe, sda_oe, scl, sda, busy, rdy, smp, tmo;
	int   failures = 0, tests_run = 0, oc = 0, ns = 0;
	logic scl_do, sda_do, exp_bit;
	logic q[$];
	always #25 clk = ~clk;
	always @(negedge clk) begin
		oc <= (oc + 1) % 16;
		ovf <= oc == 15;
	end
	always @(negedge clk) if (smp === 1'b1) begin
		ns++;
		exp_bit = q.pop_front();
		`CHK("sda", exp_bit, sda)
	end
	bus_timing #(.TIMEOUT_CYCLES(TO)) i_bus_timing (.CLK_SYS(clk), .RST_N(rst_n), .CE(1'b1), .OVERFLOW(ovf),
		.START_REQ(sr), .BIT_REQ(br), .BIT_DATA(bd), .STOP_REQ(pr), .EXTENDED_HOLD_ENABLE(ext),
		.DATA_DELAY_EXTENSION(dly), .SCL_IN(scl), .SDA_IN(sda), .SCL_OUT(scl_do), .SCL_OE(scl_oe), .SDA_OUT(sda_do),
		.SDA_OE(sda_oe), .BUSY(busy), .READY(rdy), .BIT_SAMPLE(smp), .TIMEOUT(tmo));
	bus_follower i_bus_follower (.scl_oe(scl_oe), .sda_oe(sda_oe), .hold_scl(hs), .scl(scl), .sda(sda));
	task automatic wait_on(ref logic s, input logic v);
		int n;
		for (n = 0; s !== v && n < 999; n++) @(negedge clk);
		if (s !== v) failures++;
	endtask
	task automatic step(input logic s, b, d, p);
		int n;
		repeat (2) @(negedge clk);
		for (n = 0; rdy !== 1'b1 && busy === 1'b1 && n < 999; n++) @(negedge clk);
		if (n >= 999) failures++;
		@(posedge clk iff ovf);
		@(negedge clk);
		{sr, br, bd, pr, ext, dly} <= {s, b, d, p, 2'($urandom)};
		if (b) q.push_back(d);
		@(negedge clk);
		{sr, br, pr} <= 3'h0;
	endtask
	// Eight bits per group, plus the closing bit and the bit after the START that follows the STOP
	function automatic int exp_bits(input int groups);
		return groups * 8 + 2;
	endfunction
	task automatic stop_test;
		$display("Checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		void'($urandom(4));
		repeat (8) @(posedge clk);
		@(negedge clk) rst_n <= 1;
		step(1, 0, 0, 0);
		for (int i = 0; i < 3; i++) begin
			repeat (8) step(0, 1, 1'($urandom), 0);
			step(i < 2, i == 2, 0, 0);
		end
		step(0, 0, 0, 1);
		@(negedge clk);
		sr <= 1;
		wait_on(sda_oe, 1'b0);
		wait_on(sda_oe, 1'b1);
		sr <= 0;
		`CHK("busy", 1'b1, busy)
		step(0, 1, 1, 0);
		step(0, 0, 0, 1);
		wait_on(busy, 1'b0);
		`CHK("idle", 1'b0, busy)
		`CHK("bits", exp_bits(3), ns)
		hs <= 1;
		repeat (TO - 9) @(negedge clk);
		hs <= 0;
		@(negedge clk) hs <= 1;
		repeat (TO - 9) @(negedge clk);
		`CHK("restart", 1'b0, tmo)
		repeat (20) @(negedge clk);
		`CHK("timeout", 1'b1, tmo)
		hs <= 0;
		repeat (4) @(negedge clk);
		`CHK("clear", 1'b0, tmo)
		step(1, 0, 0, 0);
		wait_on(rdy, 1'b1);
		repeat (TO + 8) @(negedge clk);
		`CHK("abort", 1'b0, busy)
		`CHK("drive", 2'h0, {scl_do, sda_do})
		stop_test;
	end
	initial begin
		#2000000;
		failures++;
		stop_test;
	end
endmodule // bus_timing_tb
`default_nettype wire

// ### common/bus_timing_defs.vh
// Constants for the two-wire leader bus timing generator.
// Assumes a 20 MHz system clock and a clock-source overflow strobe from outside.
`ifndef BUS_TIMING_DEFS_VH
`define BUS_TIMING_DEFS_VH
`define LOW_PERIODS        2'h1
`define HIGH_PERIODS       2'h2
`define BUF_PERIODS        2'h2
`define HD_STA_PERIODS     2'h1
`define SU_STA_PERIODS     2'h2
`define SU_STO_PERIODS     2'h2
`define CLK_PERIOD_NS      50
`define TIMEOUT_MS         25
`define TIMEOUT_CYCLES     ((`TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)
`define HOLD_BASE_CYCLES   4'h2
`define HOLD_EXT_CYCLES    4'h6
`define HOLD_DLY_CYCLES    4'h4
`define ST_IDLE            4'h0
`define ST_BUF             4'h1
`define ST_SU_STA          4'h2
`define ST_HD_STA          4'h3
`define ST_LOW             4'h4
`define ST_HIGH            4'h5
`define ST_SU_STO_LOW      4'h6
`define ST_SU_STO          4'h7
`define ST_READY           4'h8
`endif

// ### core/bus_timing.v
// Leader bus timing generator: START, bit clocking, repeated START, STOP.
// Assumes overflow strobe, requests and pin inputs synchronous to CLK_SYS.
`timescale 1ns/1ps
`default_nettype none
`include "bus_timing_defs.vh"
module bus_timing #(
	parameter integer TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
	input  wire CLK_SYS,
	input  wire RST_N,
	input  wire CE,
	input  wire OVERFLOW,
	input  wire START_REQ,
	input  wire BIT_REQ,
	input  wire BIT_DATA,
	input  wire STOP_REQ,
	input  wire EXTENDED_HOLD_ENABLE,
	input  wire DATA_DELAY_EXTENSION,
	input  wire SCL_IN,
	input  wire SDA_IN,
	output reg  SCL_OUT,
	output reg  SCL_OE,
	output reg  SDA_OUT,
	output reg  SDA_OE,
	output reg  BUSY,
	output reg  READY,
	output reg  BIT_SAMPLE,
	output reg  TIMEOUT
);
	// ----------------------------------------
	// State and counters
	// ----------------------------------------
	reg [3:0] state_ff;
	reg [3:0] nxt_state;
	reg [1:0] per_ff;
	reg [1:0] nxt_per;
	reg       sda_low_ff;
	reg       nxt_sda_low;
	reg       scl_low_ff;
	reg       nxt_scl_low;
	reg       bit_ff;
	reg       nxt_bit;
	reg       sample_ff;
	reg       nxt_sample;
	reg       pend_ff;
	reg       nxt_pend;
	reg [3:0] hold_ff;
	reg [3:0] nxt_hold;
	reg       started_ff;
	reg       nxt_started;
	wire      timeout_w;
	wire [3:0] hold_len = EXTENDED_HOLD_ENABLE ?
		(DATA_DELAY_EXTENSION ? `HOLD_EXT_CYCLES + `HOLD_DLY_CYCLES : `HOLD_EXT_CYCLES) :
		`HOLD_BASE_CYCLES;
	// Last overflow period of each timed state
	wire      low_done  = OVERFLOW && (per_ff == (`LOW_PERIODS - 2'h1));
	wire      high_done = OVERFLOW && (per_ff == (`HIGH_PERIODS - 2'h1));
	wire      buf_done  = OVERFLOW && (per_ff == (`BUF_PERIODS - 2'h1));
	wire      hd_done   = OVERFLOW && (per_ff == (`HD_STA_PERIODS - 2'h1));
	wire      sta_done  = OVERFLOW && (per_ff == (`SU_STA_PERIODS - 2'h1));
	wire      sto_done  = OVERFLOW && (per_ff == (`SU_STO_PERIODS - 2'h1));
	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always @* begin
		nxt_state = state_ff;
		nxt_per = OVERFLOW ? per_ff + 2'h1 : per_ff;
		nxt_sda_low = sda_low_ff;
		nxt_scl_low = scl_low_ff;
		nxt_bit = bit_ff;
		nxt_sample = 1'b0;
		nxt_pend = pend_ff;
		nxt_hold = (hold_ff != 4'h0) ? hold_ff - 4'h1 : 4'h0;
		nxt_started = started_ff;
		if (hold_ff == 4'h1)
			nxt_sda_low = ~bit_ff;
		case (state_ff)
		`ST_IDLE: begin
			nxt_per = 2'h0;
			nxt_scl_low = 1'b0;
			nxt_sda_low = 1'b0;
			if (START_REQ) begin
				nxt_state = `ST_BUF;
			end
		end
		`ST_BUF: begin
			if (buf_done && SCL_IN && SDA_IN) begin
				nxt_state = `ST_HD_STA;
				nxt_sda_low = 1'b1;
				nxt_per = 2'h0;
			end
		end
		`ST_SU_STA: begin
			nxt_scl_low = 1'b0;
			nxt_sda_low = 1'b0;
			if (!SCL_IN)
				nxt_per = 2'h0;                    // Clock stretching
			else if (sta_done) begin
				nxt_state = `ST_HD_STA;
				nxt_sda_low = 1'b1;
				nxt_per = 2'h0;
			end
		end
		`ST_HD_STA: begin
			if (hd_done) begin
				nxt_state = `ST_READY;
				nxt_scl_low = 1'b1;
				nxt_per = 2'h0;
				nxt_started = 1'b1;
			end
		end
		`ST_READY: begin
			nxt_per = 2'h0;
			if (BIT_REQ) begin
				nxt_bit = BIT_DATA;
				nxt_hold = hold_len;
				nxt_state = `ST_LOW;
			end else if (START_REQ) begin
				nxt_state = `ST_LOW;
				nxt_bit = 1'b1;
				nxt_pend = 1'b1;
				nxt_hold = hold_len;
			end else if (STOP_REQ) begin
				nxt_state = `ST_SU_STO_LOW;
				nxt_bit = 1'b0;
				nxt_hold = hold_len;
			end
		end
		`ST_LOW: begin
			if (low_done) begin
				nxt_per = 2'h0;
				if (pend_ff) begin
					nxt_pend = 1'b0;
					nxt_state = `ST_SU_STA;
				end else begin
					nxt_scl_low = 1'b0;
					nxt_state = `ST_HIGH;
				end
			end
		end
		`ST_HIGH: begin
			if (!SCL_IN)
				nxt_per = 2'h0;
			else if (high_done) begin
				nxt_sample = 1'b1;
				nxt_bit = SDA_IN;
				nxt_scl_low = 1'b1;
				nxt_per = 2'h0;
				nxt_state = `ST_READY;
			end
		end
		`ST_SU_STO_LOW: begin
			if (low_done) begin
				nxt_scl_low = 1'b0;
				nxt_per = 2'h0;
				nxt_state = `ST_SU_STO;
			end
		end
		`ST_SU_STO: begin
			if (!SCL_IN)
				nxt_per = 2'h0;
			else if (sto_done) begin
				nxt_sda_low = 1'b0;
				nxt_per = 2'h0;
				nxt_started = 1'b0;
				nxt_state = `ST_BUF;
			end
		end
		default: begin
			nxt_state = `ST_IDLE;
		end
		endcase
		if (nxt_state == `ST_BUF && state_ff == `ST_SU_STO && !START_REQ)
			nxt_state = `ST_IDLE;
		if (timeout_w && started_ff) begin
			nxt_state = `ST_IDLE;
			nxt_started = 1'b0;
			nxt_pend = 1'b0;
			nxt_hold = 4'h0;
		end
	end
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			state_ff   <= `ST_IDLE;
			per_ff     <= 2'h0;
			sda_low_ff <= 1'b0;
			scl_low_ff <= 1'b0;
			bit_ff     <= 1'b1;
			sample_ff  <= 1'b0;
			pend_ff    <= 1'b0;
			hold_ff    <= 4'h0;
			started_ff <= 1'b0;
		end else if (CE) begin
			state_ff   <= nxt_state;
			per_ff     <= nxt_per;
			sda_low_ff <= nxt_sda_low;
			scl_low_ff <= nxt_scl_low;
			bit_ff     <= nxt_bit;
			sample_ff  <= nxt_sample;
			pend_ff    <= nxt_pend;
			hold_ff    <= nxt_hold;
			started_ff <= nxt_started;
		end
	end
	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			SCL_OUT    <= 1'b0;
			SCL_OE     <= 1'b0;
			SDA_OUT    <= 1'b0;
			SDA_OE     <= 1'b0;
			BUSY       <= 1'b0;
			READY      <= 1'b0;
			BIT_SAMPLE <= 1'b0;
			TIMEOUT    <= 1'b0;
		end else if (CE) begin
			SCL_OE     <= nxt_scl_low;
			SDA_OE     <= nxt_sda_low;
			BUSY       <= (nxt_state != `ST_IDLE);
			READY      <= (nxt_state == `ST_READY);
			BIT_SAMPLE <= nxt_sample;
			TIMEOUT    <= timeout_w;
		end
	end
	scl_low_timeout #(
		.TIMEOUT_CYCLES (TIMEOUT_CYCLES)
	) u_timeout (
		.clk        (CLK_SYS),
		.rst_n      (RST_N),
		.ce         (CE),
		.scl        (SCL_IN),
		.timeout_ff (timeout_w)
	);
endmodule // bus_timing
`default_nettype wire

// ### core/scl_low_timeout.v
// SCL clock-low timeout detector.
// Assumes SCL input synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "bus_timing_defs.vh"
module scl_low_timeout #(
	parameter integer TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
	input  wire clk,
	input  wire rst_n,
	input  wire ce,
	input  wire scl,
	output reg  timeout_ff
);
	reg [24:0] count_ff;
	reg [24:0] nxt_count;
	reg        nxt_timeout;
	always @* begin
		nxt_count = count_ff;
		nxt_timeout = timeout_ff;
		if (scl) begin
			nxt_count = 25'h0;
			nxt_timeout = 1'b0;
		end else if (count_ff >= TIMEOUT_CYCLES[24:0] - 25'h1) begin
			nxt_timeout = 1'b1;
		end else begin
			nxt_count = count_ff + 25'h1;
		end
	end
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_ff   <= 25'h0;
			timeout_ff <= 1'b0;
		end else if (ce) begin
			count_ff   <= nxt_count;
			timeout_ff <= nxt_timeout;
		end
	end
endmodule // scl_low_timeout
`default_nettype wire
